//--- bench/dssc_ctrl_model.sv
// Purpose: memory controller model for the ddr sram core
// Assumes: one cyc call is one 160 ns link cycle, driven on clk falling edges
// Notes:   link clock stands still between calls; released lines show inverse data
`timescale 1ns/10ps
module dssc_ctrl_model (
   input  wire        clk,
   input  wire [1:0]  select_polarity_straps,
   input  wire [17:0] dq_out,
   input  wire        dq_oe,
   output reg         mem_clock,
   output reg  [18:0] pair_address,
   output reg         write_n,
   output reg         primary_select_n,
   output reg  [1:0]  secondary_selects,
   output reg  [17:0] dq_in,
   output reg  [17:0] q0,
   output reg  [17:0] q1,
   output reg         oe_seen
);
   initial begin
      {mem_clock, pair_address, write_n, primary_select_n} = 22'h000003;
      {secondary_selects, dq_in, q0, q1, oe_seen} = 57'h0;
   end
   // ====================
   // link cycle; q0/q1/oe_seen capture the previous command's answer
   task cyc(input wr, input [1:0] ok, input [18:0] a, input [17:0] d0, input [17:0] d1);
      begin
         @(negedge clk);
         pair_address = a;
         write_n = !wr;
         primary_select_n = !ok[0];
         secondary_selects = ok[1] ? select_polarity_straps : ~select_polarity_straps;
         dq_in = d0;
         repeat (2) @(negedge clk);
         mem_clock = 1'b1;
         repeat (3) @(negedge clk);
         dq_in = d1;
         repeat (3) @(negedge clk);
         mem_clock = 1'b0;
         repeat (2) @(negedge clk);
         q0 = dq_out;
         oe_seen = dq_oe;
         repeat (3) @(negedge clk);
         pair_address = ~a;
         dq_in = ~d1;
         repeat (2) @(negedge clk);
         q1 = dq_out;
      end
   endtask
endmodule

//--- bench/dssc_properties.sv
// Purpose: port assertions for the ddr sram core
// Assumes: link inputs stable from 2 clk before a rise; 16 clk per link cycle
// Notes:   output checks look 8 clk past the next link rise, clear of sync jitter
`timescale 1ns/10ps
`include "dssc_defs.vh"
module dssc_chk (
   input wire                    clk,
   input wire                    reset,
   input wire                    mem_clock,
   input wire                    write_n,
   input wire                    primary_select_n,
   input wire [1:0]              secondary_selects,
   input wire [1:0]              select_polarity_straps,
   input wire [`DSSC_DATA_W-1:0] dq_out,
   input wire                    dq_oe,
   input wire                    echo_timing_out,
   input wire                    echo_timing_out_n
);
   // ====================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire sel_ok = !primary_select_n && (secondary_selects == select_polarity_straps);
   chk_echo_rise: assert property ($rose(mem_clock) |-> ##[3:7] echo_timing_out)
      else $error("echo missed a link rise");
   chk_echo_fall: assert property ($fell(mem_clock) |-> ##[3:7] !echo_timing_out)
      else $error("echo missed a link fall");
   chk_echo_pair: assert property (echo_timing_out != echo_timing_out_n)
      else $error("echo pair not complementary");
   chk_read_drive: assert property (($rose(mem_clock) && sel_ok && write_n)
      ##16 $rose(mem_clock) |-> ##8 dq_oe) else $error("read not driven");
   chk_write_quiet: assert property (($rose(mem_clock) && sel_ok && !write_n)
      ##16 $rose(mem_clock) |-> ##8 !dq_oe) else $error("write drove outputs");
   chk_desel_quiet: assert property (($rose(mem_clock) && !sel_ok)
      ##16 $rose(mem_clock) |-> ##8 !dq_oe) else $error("deselect drove outputs");
   chk_oe_span: assert property ($rose(dq_oe) |-> dq_oe[*8])
      else $error("drive window too short");
   chk_oe_echo: assert property ($rose(dq_oe) |-> $rose(echo_timing_out))
      else $error("drive start not on echo rise");
   chk_data_edge: assert property (dq_oe && !$stable(dq_out) |-> !$stable(echo_timing_out))
      else $error("data moved off an echo edge");
endmodule
bind dssc_core dssc_chk CHK (.clk(clk), .reset(reset), .mem_clock(mem_clock),
   .write_n(write_n), .primary_select_n(primary_select_n),
   .secondary_selects(secondary_selects), .select_polarity_straps(select_polarity_straps),
   .dq_out(dq_out), .dq_oe(dq_oe), .echo_timing_out(echo_timing_out),
   .echo_timing_out_n(echo_timing_out_n));

//--- bench/tb_top.sv
// Purpose: self-checking bench for the ddr sram core
// Assumes: controller model paces the link at 160 ns
// Notes:   unwritten storage is unknown, so only written pairs are read
`timescale 1ns/10ps
module tb_top;
   reg         clk = 1'b0;
   reg         reset = 1'b1;
   reg  [1:0]  straps = 2'h0;
   wire        mem_clock, write_n, sel_n, dq_oe, echo, echo_n, oe_seen;
   wire [18:0] addr;
   wire [1:0]  sels;
   wire [17:0] dq_in, dq_out, q0, q1;
   integer     failures = 0;
   integer     num_checks = 0;
   integer     s;
   always #5 clk = ~clk;
   dssc_core DUT (.clk(clk), .reset(reset), .mem_clock(mem_clock), .pair_address(addr),
      .write_n(write_n), .primary_select_n(sel_n), .secondary_selects(sels),
      .select_polarity_straps(straps), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .echo_timing_out(echo), .echo_timing_out_n(echo_n));
   dssc_ctrl_model PM (.clk(clk), .select_polarity_straps(straps), .dq_out(dq_out),
      .dq_oe(dq_oe), .mem_clock(mem_clock), .pair_address(addr), .write_n(write_n),
      .primary_select_n(sel_n), .secondary_selects(sels), .dq_in(dq_in), .q0(q0),
      .q1(q1), .oe_seen(oe_seen));
   // ====================
   // checking and closing
   task chk(input [63:0] nm, input [17:0] exp, input [17:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task idle;
      PM.cyc(1'b0, 2'h0, 19'h00000, 18'h00000, 18'h00000);
   endtask
   // ====================
   // scenarios
   task t_coherent;
      begin
         straps = 2'h2;
         repeat (8) @(negedge clk);
         PM.cyc(1'b1, 2'h3, 19'h00007, 18'h0AAAA, 18'h15555);
         PM.cyc(1'b0, 2'h3, 19'h00007, 18'h00000, 18'h00000);
         chk("wr_oe", 18'h00000, {17'h0, oe_seen});
         idle;
         chk("rd_oe", 18'h00001, {17'h0, oe_seen});
         chk("rd_w0", 18'h0AAAA, q0);
         chk("rd_w1", 18'h15555, q1);
         idle;
         chk("ds_oe", 18'h00000, {17'h0, oe_seen});
         $display("test coherent done");
      end
   endtask
   task t_straps;
      for (s = 0; s < 4; s = s + 1) begin
         straps = s[1:0];
         repeat (8) @(negedge clk);
         PM.cyc(1'b1, 2'h3, {17'h8, s[1:0]}, 18'h20000 + s, 18'h01000 + s);
         PM.cyc(1'b1, s[0] ? 2'h1 : 2'h2, {17'h8, s[1:0]}, 18'h3FFFF, 18'h3FFFF);
         PM.cyc(1'b0, 2'h3, {17'h8, s[1:0]}, 18'h00000, 18'h00000);
         chk("bad_oe", 18'h00000, {17'h0, oe_seen});
         idle;
         chk("st_w0", 18'h20000 + s, q0);
         chk("st_w1", 18'h01000 + s, q1);
         $display("test straps %0d done", s);
      end
   endtask
   task t_pairs;
      begin
         PM.cyc(1'b1, 2'h3, 19'h00003, 18'h00333, 18'h33300);
         PM.cyc(1'b1, 2'h3, 19'h00004, 18'h00444, 18'h04440);
         PM.cyc(1'b0, 2'h3, 19'h00003, 18'h00000, 18'h00000);
         PM.cyc(1'b0, 2'h3, 19'h00004, 18'h00000, 18'h00000);
         chk("p3_w0", 18'h00333, q0);
         chk("p3_w1", 18'h33300, q1);
         idle;
         chk("p4_oe", 18'h00001, {17'h0, oe_seen});
         chk("p4_w0", 18'h00444, q0);
         chk("p4_w1", 18'h04440, q1);
         $display("test pairs done");
      end
   endtask
   // read answered while a later write to the same pair lands
   task t_rd_first;
      begin
         PM.cyc(1'b1, 2'h3, 19'h00005, 18'h00555, 18'h05550);
         PM.cyc(1'b0, 2'h3, 19'h00005, 18'h00000, 18'h00000);
         PM.cyc(1'b1, 2'h3, 19'h00005, 18'h2AAAA, 18'h15554);
         chk("of_w0", 18'h00555, q0);
         chk("of_w1", 18'h05550, q1);
         PM.cyc(1'b0, 2'h3, 19'h00005, 18'h00000, 18'h00000);
         idle;
         chk("nw_w0", 18'h2AAAA, q0);
         chk("nw_w1", 18'h15554, q1);
         $display("test read first done");
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (8) @(negedge clk);
      t_coherent;
      t_straps;
      t_pairs;
      t_rd_first;
      stop_test;
   end
   initial begin
      #40000;
      failures = failures + 1;
      stop_test;
   end
endmodule

//--- shared/dssc_defs.vh
// Purpose: constants for the double-data-rate synchronous static ram core
// Assumes: included by every design file of the core
// Notes:   widths fixed at the x18 organisation, 1M words
`ifndef DSSC_DEFS_VH
`define DSSC_DEFS_VH

// =====================================================================
// organisation
`define DSSC_DATA_W      18
`define DSSC_PAIR_W      19
`define DSSC_WORD_W      20
`define DSSC_DEPTH       1048576

// =====================================================================
// lowest address bit values for the two halves
`define DSSC_HALF_RISE   1'b0
`define DSSC_HALF_FALL   1'b1

// =====================================================================
// synchroniser and idle values
`define DSSC_SYNC_STAGES 3
`define DSSC_DATA_IDLE   18'h00000
`define DSSC_PAIR_IDLE   19'h00000

`endif

//--- src/dssc_core.v
// Purpose: double-data-rate synchronous static ram core, device side
// Assumes: memory clock and all pins sampled by clk, memory clock much slower
// Notes:   storage not cleared by reset; dq is split into in, out and enable
//
// Behaviour
// - address and read/write control taken on each rising memory clock edge.
// - write starts at the capturing rising edge and completes internally.
// - write data taken on both rising and falling memory clock edges.
// - read data driven on both memory clock edges, one word each.
// - lowest internal address bit is zero for the rising-edge word.
// - lowest internal address bit is one for the falling-edge word.
// - external address names word pairs; lowest bit never driven externally.
// - read data waits at output register inputs during the access cycle.
// - staged word released at next rising edge, second at following falling.
// - read released while a later write to the same pair lands returns the old data.
// - echo clock outputs follow the same output register path as data.
// - each secondary select takes its active polarity from a static strap.
`timescale 1ns/10ps
`include "dssc_defs.vh"

module dssc_core (
   clk,
   reset,
   mem_clock,
   pair_address,
   write_n,
   primary_select_n,
   secondary_selects,
   select_polarity_straps,
   dq_in,
   dq_out,
   dq_oe,
   echo_timing_out,
   echo_timing_out_n
);
   input  wire                      clk;
   input  wire                      reset;
   input  wire                      mem_clock;
   input  wire [`DSSC_PAIR_W-1:0]   pair_address;
   input  wire                      write_n;
   input  wire                      primary_select_n;
   input  wire [1:0]                secondary_selects;
   input  wire [1:0]                select_polarity_straps;
   input  wire [`DSSC_DATA_W-1:0]   dq_in;
   output reg  [`DSSC_DATA_W-1:0]   dq_out;
   output reg                       dq_oe;
   output reg                       echo_timing_out;
   output reg                       echo_timing_out_n;

   // =====================================================================
   // helpers
   function [`DSSC_WORD_W-1:0] word_addr;
      input [`DSSC_PAIR_W-1:0] pair;
      input                    half;
      begin
         word_addr = {pair, half};
      end
   endfunction

   // =====================================================================
   // pin sampling
   // one synchroniser for everything keeps data aligned with the clock edge
   localparam SYNC_W = 1 + `DSSC_PAIR_W + 1 + 1 + 2 + 2 + `DSSC_DATA_W;

   wire [SYNC_W-1:0]             pins_raw;
   wire [SYNC_W-1:0]             pins_sync;
   wire                          ck_s;
   wire [`DSSC_PAIR_W-1:0]       addr_s;
   wire                          write_n_s;
   wire                          psel_n_s;
   wire [1:0]                    ssel_s;
   wire [1:0]                    strap_s;
   wire [`DSSC_DATA_W-1:0]       din_s;

   assign pins_raw = {mem_clock, pair_address, write_n, primary_select_n,
                      secondary_selects, select_polarity_straps, dq_in};
   assign {ck_s, addr_s, write_n_s, psel_n_s, ssel_s, strap_s, din_s} = pins_sync;

   dssc_sync #(
      .WIDTH     (SYNC_W)
   ) u_sync (
      .clk       (clk),
      .reset     (reset),
      .async_in  (pins_raw),
      .level_out (pins_sync)
   );

   // =====================================================================
   // edge detection
   reg  ck_prev_reg;
   wire ck_rise;
   wire ck_fall;

   assign ck_rise = ck_s & ~ck_prev_reg;
   assign ck_fall = ~ck_s & ck_prev_reg;

   always @(posedge clk) begin
      if (reset) begin
         ck_prev_reg <= 1'b0;
      end else begin
         ck_prev_reg <= ck_s;
      end
   end

   // =====================================================================
   // command decode
   // straps are static, so sampling them every edge costs nothing
   wire selected;
   wire start_write;
   wire start_read;

   assign selected    = ~psel_n_s & (ssel_s == strap_s);
   assign start_write = ck_rise & selected & ~write_n_s;
   assign start_read  = ck_rise & selected & write_n_s;

   // =====================================================================
   // storage and write path
   reg  [`DSSC_DATA_W-1:0]  mem_reg [0:`DSSC_DEPTH-1];
   reg                      wr_fall_pend_reg;
   reg  [`DSSC_PAIR_W-1:0]  wr_pair_reg;

   // self-timed: rising word stored at once, falling word at the fall
   // both words land before the next rise, so no later read meets a pending write
   always @(posedge clk) begin
      if (start_write) begin
         mem_reg[word_addr(addr_s, `DSSC_HALF_RISE)] <= din_s;
      end else if (ck_fall & wr_fall_pend_reg) begin
         mem_reg[word_addr(wr_pair_reg, `DSSC_HALF_FALL)] <= din_s;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         wr_fall_pend_reg <= 1'b0;
         wr_pair_reg      <= `DSSC_PAIR_IDLE;
      end else if (start_write) begin
         wr_fall_pend_reg <= 1'b1;
         wr_pair_reg      <= addr_s;
      end else if (ck_fall) begin
         wr_fall_pend_reg <= 1'b0;
      end
   end

   // =====================================================================
   // read path
   // access cycle holds the pair; words read at the release edges
   reg                      rd_pend_reg;
   reg  [`DSSC_PAIR_W-1:0]  rd_pair_reg;
   reg                      hi_pend_reg;
   reg  [`DSSC_PAIR_W-1:0]  hi_pair_reg;
   wire [`DSSC_DATA_W-1:0]  word_rise;
   wire [`DSSC_DATA_W-1:0]  word_fall;

   // words fetched ahead of any write taken at the release edge,
   // so a write issued after the read never leaks into its data
   function [`DSSC_DATA_W-1:0] stored_word;
      input [`DSSC_PAIR_W-1:0] pair;
      input                    half;
      begin
         stored_word = mem_reg[word_addr(pair, half)];
      end
   endfunction

   assign word_rise = stored_word(rd_pair_reg, `DSSC_HALF_RISE);
   assign word_fall = stored_word(hi_pair_reg, `DSSC_HALF_FALL);

   always @(posedge clk) begin
      if (reset) begin
         rd_pend_reg <= 1'b0;
         rd_pair_reg <= `DSSC_PAIR_IDLE;
      end else if (ck_rise) begin
         rd_pend_reg <= start_read;
         if (start_read) begin
            rd_pair_reg <= addr_s;
         end
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         hi_pend_reg <= 1'b0;
         hi_pair_reg <= `DSSC_PAIR_IDLE;
      end else if (ck_rise) begin
         hi_pend_reg <= rd_pend_reg;
         hi_pair_reg <= rd_pair_reg;
      end else if (ck_fall) begin
         hi_pend_reg <= 1'b0;
      end
   end

   // =====================================================================
   // output registers
   // limitation: words appear several clk cycles after the pin edge
   always @(posedge clk) begin
      if (reset) begin
         dq_out <= `DSSC_DATA_IDLE;
         dq_oe  <= 1'b0;
      end else if (ck_rise) begin
         dq_oe <= rd_pend_reg;
         if (rd_pend_reg) begin
            dq_out <= word_rise;
         end
      end else if (ck_fall & hi_pend_reg) begin
         dq_out <= word_fall;
      end
   end

   // echo clocks share the same edge timing as the data registers
   always @(posedge clk) begin
      if (reset) begin
         echo_timing_out   <= 1'b0;
         echo_timing_out_n <= 1'b1;
      end else if (ck_rise) begin
         echo_timing_out   <= 1'b1;
         echo_timing_out_n <= 1'b0;
      end else if (ck_fall) begin
         echo_timing_out   <= 1'b0;
         echo_timing_out_n <= 1'b1;
      end
   end
endmodule

//--- src/dssc_sync.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from outside the clk domain
// Notes:   the output moves only when stages two and three agree
`timescale 1ns/10ps
`include "dssc_defs.vh"

module dssc_sync #(
   parameter WIDTH = 1
) (
   clk,
   reset,
   async_in,
   level_out
);
   input  wire             clk;
   input  wire             reset;
   input  wire [WIDTH-1:0] async_in;
   output wire [WIDTH-1:0] level_out;

   reg  [WIDTH-1:0] meta_reg;
   reg  [WIDTH-1:0] stage2_reg;
   reg  [WIDTH-1:0] stage3_reg;
   reg  [WIDTH-1:0] level_reg;
   wire [WIDTH-1:0] level_next;
   wire [WIDTH-1:0] agree;

   // =====================================================================
   // filter
   // first stage feeds only the second; per-bit agreement
   assign agree      = ~(stage2_reg ^ stage3_reg);
   assign level_next = (agree & stage3_reg) | (~agree & level_reg);
   assign level_out  = level_reg;

   always @(posedge clk) begin
      if (reset) begin
         meta_reg   <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
         stage3_reg <= {WIDTH{1'b0}};
         level_reg  <= {WIDTH{1'b0}};
      end else begin
         meta_reg   <= async_in;
         stage2_reg <= meta_reg;
         stage3_reg <= stage2_reg;
         level_reg  <= level_next;
      end
   end
endmodule
